//--- design/key_switch_map.vh
// Purpose: constants of the local key and switch control
// Assumes: 10 MHz system clock
// Notes: offsets are held in hundredths of a millimetre
`ifndef KEY_SWITCH_MAP_VH
`define KEY_SWITCH_MAP_VH

// ****************************************
// clock and times
// ****************************************
// counts in clk_i cycles; retune them if the clock changes
`define T_FACTORY_CYC 29'h7270e00
`define T_UNIT_CYC 29'h1c9c380
`define T_REPEAT_START_CYC 29'h1312d00
`define T_FINISH_CYC 29'h1c9c380
`define T_TIMEOUT_CYC 29'h11e1a300
`define T_REPEAT_CYC 29'h01e8480
`define T_BLINK_CYC 29'h04c4b40
`define T_DEBOUNCE_CYC 20'h186a0

// ****************************************
// steps, reset values, scaling
// ****************************************
`define STEP_MM 16'h0064
`define STEP_INCH 16'h007f
`define OFFSET_RESET 16'h0000
`define UNIT_INCH_RESET 1'b0
`define PCT_FULL 7'h64
`define KEYS_NONE 2'h0
`define KEYS_DOWN 2'h1
`define KEYS_UP 2'h2
`define KEYS_BOTH 2'h3
`define SEL_LIQUID 2'h0
`define SEL_PRODUCT 2'h1
`define SEL_WATER 2'h2

`endif

//--- design/input_filter.v
// Purpose: two-stage synchroniser with stability filter for a pin
// Assumes: input is asynchronous to clk_i
// Notes: output changes only after the synced level holds STABLE_CYC cycles
`timescale 1ns/1ps
module input_filter #(
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] STABLE_CYC = 20'd100000
) (
  input wire clk_i,
  input wire rstn_i,
  input wire pin_i,
  output reg level_o
);

  reg sync1;
  reg sync2;
  reg [CNT_W-1:0] cnt;

  // ****************************************
  // synchroniser and filter
  // ****************************************
  // only sync2 reads sync1, to keep metastability out of the counter
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt <= {CNT_W{1'b0}};
      level_o <= 1'b0;
    end
    else
    begin
      sync1 <= pin_i;
      sync2 <= sync1;
      if (sync2 == level_o)
        cnt <= {CNT_W{1'b0}};
      else if (cnt == STABLE_CYC - 1'b1)
      begin
        cnt <= {CNT_W{1'b0}};
        level_o <= sync2;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

endmodule

//--- design/local_key_switch_control.v
// Purpose: local keys, DIP switches and status indicators of the transmitter
// Assumes: keys and switches are pins, high when pressed or ON
// Notes: status inputs come from logic on clk_i and are not synchronised
//
// Function
// - both keys held twelve seconds outside adjust restores all settings to factory defaults
// - up key alone 3 s selects metric, enters adjust, blinks, shows mm
// - down key alone 3 s selects inch, enters adjust, blinks, shows inch
// - in adjust, up press raises the offset, down press lowers it
// - metric step is 1 mm; a raise moves reported level negative
// - inch step is 0.05 in; a raise moves reported level negative
// - key held 2 s or longer keeps stepping until released
// - both keys held 3 s in adjust finishes and keeps the value
// - no key for more than 30 s leaves adjust and saves
// - write-protect switch ON blocks menu writes, OFF permits them
// - hardware lock clears only by changing the switch itself
// - hardware lock reports locked status and shows a header symbol
// - compatibility switch ON selects legacy mode, OFF native, default OFF
// - communication icon flashes during HART traffic, steady off otherwise
// - lock symbol shown whenever software has locked the device
// - alarm stops measuring, outputs alarm value, raises diagnostic, red display
// - warning keeps measuring and raises a diagnostic message
// - percent bar scales primary temperature, 0 at lower, 100 upper limit
// - display is output only, accepts no operating input
`timescale 1ns/1ps
`include "key_switch_map.vh"
module local_key_switch_control #(
  parameter OFS_W = 16,
  parameter TMP_W = 16,
  parameter LVL_W = 24,
  parameter [28:0] FACTORY_CYC = `T_FACTORY_CYC,
  parameter [28:0] UNIT_CYC = `T_UNIT_CYC,
  parameter [28:0] REP_START_CYC = `T_REPEAT_START_CYC,
  parameter [28:0] FINISH_CYC = `T_FINISH_CYC,
  parameter [28:0] TIMEOUT_CYC = `T_TIMEOUT_CYC,
  parameter [28:0] REPEAT_CYC = `T_REPEAT_CYC,
  parameter [28:0] BLINK_CYC = `T_BLINK_CYC,
  parameter [19:0] DEBOUNCE_CYC = `T_DEBOUNCE_CYC
) (
  input wire clk_i,
  input wire rstn_i,
  input wire up_key_i,
  input wire down_key_i,
  input wire write_protect_sw_i,
  input wire compat_sw_i,
  input wire menu_write_req_i,
  input wire hart_active_i,
  input wire sw_lock_i,
  input wire alarm_i,
  input wire warning_i,
  input wire [1:0] primary_value_select_i,
  input wire signed [TMP_W-1:0] liquid_temp_i,
  input wire signed [TMP_W-1:0] product_temp_i,
  input wire signed [TMP_W-1:0] water_temp_i,
  input wire signed [TMP_W-1:0] range_lower_i,
  input wire signed [TMP_W-1:0] range_upper_i,
  input wire signed [TMP_W-1:0] alarm_value_i,
  input wire signed [LVL_W-1:0] level_raw_i,
  output wire menu_write_grant_o,
  output reg factory_reset_o,
  output reg unit_inch_o,
  output wire adjust_mode_o,
  output wire blink_all_o,
  output reg signed [OFS_W-1:0] offset_o,
  output reg offset_save_o,
  output reg signed [LVL_W-1:0] level_o,
  output wire hw_locked_o,
  output wire wp_symbol_o,
  output wire legacy_compat_mode_o,
  output wire comm_icon_o,
  output wire lock_symbol_o,
  output wire measure_stop_o,
  output reg signed [TMP_W-1:0] loop_value_o,
  output reg diag_msg_o,
  output reg display_red_o,
  output reg [6:0] percent_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ADJ = 1'b1;
  localparam [28:0] CNT_MAX = 29'h1fffffff;

  wire up_key;
  wire down_key;
  wire wp_sw;
  wire compat_sw;
  wire [1:0] keys;
  wire keys_chg;
  wire hold_unit;
  wire hold_factory;
  wire hold_finish;
  wire auto_tick;
  wire step_up;
  wire step_down;
  wire timeout;
  wire signed [OFS_W-1:0] step;
  wire signed [TMP_W-1:0] pv_sel;
  reg state;
  reg next_state;
  reg armed;
  reg [1:0] keys_q;
  reg [28:0] hold_cnt;
  reg [28:0] idle_cnt;
  reg [28:0] rep_cnt;
  reg [28:0] blink_cnt;
  reg blink_phase;
  reg signed [TMP_W-1:0] pv_hold;

  // ****************************************
  // helpers
  // ****************************************
  function signed [OFS_W-1:0] sat_add;
    input signed [OFS_W-1:0] a;
    input signed [OFS_W-1:0] d;
    reg signed [OFS_W:0] s;
    begin
      s = {a[OFS_W-1], a} + {d[OFS_W-1], d};
      if (s[OFS_W] != s[OFS_W-1])
        sat_add = s[OFS_W] ? {1'b1, {(OFS_W-1){1'b0}}} : {1'b0, {(OFS_W-1){1'b1}}};
      else
        sat_add = s[OFS_W-1:0];
    end
  endfunction

  // a limit of n acts at the n-th edge of the count
  function hold_hit;
    input [28:0] cnt;
    input [28:0] lim;
    begin
      hold_hit = cnt == lim - 1'b1;
    end
  endfunction

  // clamps outside the range; an empty or inverted range reads 0
  function [6:0] pct;
    input signed [TMP_W-1:0] t;
    input signed [TMP_W-1:0] lo;
    input signed [TMP_W-1:0] hi;
    reg signed [TMP_W+8:0] num;
    reg signed [TMP_W+8:0] den;
    reg signed [TMP_W+8:0] q;
    begin
      num = ($signed({{9{t[TMP_W-1]}}, t}) - $signed({{9{lo[TMP_W-1]}}, lo})) * $signed({{(TMP_W+2){1'b0}}, `PCT_FULL});
      den = $signed({{9{hi[TMP_W-1]}}, hi}) - $signed({{9{lo[TMP_W-1]}}, lo});
      q = {(TMP_W+9){1'b0}};
      if (den <= 0 || t <= lo)
        pct = 7'h00;
      else if (t >= hi)
        pct = `PCT_FULL;
      else
      begin
        q = num / den;
        pct = q[6:0];
      end
    end
  endfunction

  // ****************************************
  // pin filters
  // ****************************************
  input_filter #(.CNT_W(20), .STABLE_CYC(DEBOUNCE_CYC)) u_up (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(up_key_i),
    .level_o(up_key)
  );
  input_filter #(.CNT_W(20), .STABLE_CYC(DEBOUNCE_CYC)) u_down (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(down_key_i),
    .level_o(down_key)
  );
  input_filter #(.CNT_W(20), .STABLE_CYC(DEBOUNCE_CYC)) u_wp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(write_protect_sw_i),
    .level_o(wp_sw)
  );
  input_filter #(.CNT_W(20), .STABLE_CYC(DEBOUNCE_CYC)) u_compat (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(compat_sw_i),
    .level_o(compat_sw)
  );

  // ****************************************
  // hold timing
  // ****************************************
  assign keys = {up_key, down_key};
  assign keys_chg = keys != keys_q;
  // single-cycle hits, so each hold acts once however long it lasts
  assign hold_unit = armed && !keys_chg && hold_hit(hold_cnt, UNIT_CYC);
  assign hold_factory = armed && !keys_chg && keys == `KEYS_BOTH && hold_hit(hold_cnt, FACTORY_CYC);
  assign hold_finish = armed && !keys_chg && keys == `KEYS_BOTH && hold_hit(hold_cnt, FINISH_CYC);
  assign auto_tick = !keys_chg && hold_cnt >= REP_START_CYC && hold_hit(rep_cnt, REPEAT_CYC);
  assign step_up = state == ST_ADJ && armed && keys == `KEYS_UP && (keys_chg || auto_tick);
  assign step_down = state == ST_ADJ && armed && keys == `KEYS_DOWN && (keys_chg || auto_tick);
  // equality one past the limit, so the quiet time strictly exceeds it
  assign timeout = state == ST_ADJ && idle_cnt == TIMEOUT_CYC;
  assign step = unit_inch_o ? `STEP_INCH : `STEP_MM;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      keys_q <= `KEYS_NONE;
      hold_cnt <= 29'h0;
      idle_cnt <= 29'h0;
      rep_cnt <= 29'h0;
    end
    else
    begin
      keys_q <= keys;
      if (keys_chg)
        hold_cnt <= 29'h0;
      else if (hold_cnt != CNT_MAX)
        hold_cnt <= hold_cnt + 1'b1;
      if (keys != `KEYS_NONE || state == ST_IDLE)
        idle_cnt <= 29'h0;
      else if (idle_cnt != CNT_MAX)
        idle_cnt <= idle_cnt + 1'b1;
      if (keys_chg || rep_cnt == REPEAT_CYC - 1'b1)
        rep_cnt <= 29'h0;
      else
        rep_cnt <= rep_cnt + 1'b1;
    end
  end

  // ****************************************
  // mode control
  // ****************************************
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (hold_unit && (keys == `KEYS_UP || keys == `KEYS_DOWN))
          next_state = ST_ADJ;
      ST_ADJ:
        if (hold_finish || timeout)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // armed clears on every mode change so a key still held from the
  // entering or finishing hold neither steps nor starts a new hold
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      armed <= 1'b0;
      factory_reset_o <= 1'b0;
      offset_save_o <= 1'b0;
      unit_inch_o <= `UNIT_INCH_RESET;
      offset_o <= `OFFSET_RESET;
    end
    else
    begin
      state <= next_state;
      factory_reset_o <= 1'b0;
      offset_save_o <= 1'b0;
      if (next_state != state)
        armed <= 1'b0;
      else if (keys == `KEYS_NONE)
        armed <= 1'b1;
      if (state == ST_IDLE && hold_factory)
      begin
        factory_reset_o <= 1'b1;
        unit_inch_o <= `UNIT_INCH_RESET;
        offset_o <= `OFFSET_RESET;
        armed <= 1'b0;
      end
      else if (state == ST_IDLE && hold_unit && keys == `KEYS_UP)
        unit_inch_o <= 1'b0;
      else if (state == ST_IDLE && hold_unit && keys == `KEYS_DOWN)
        unit_inch_o <= 1'b1;
      if (step_up)
        offset_o <= sat_add(offset_o, step);
      else if (step_down)
        offset_o <= sat_add(offset_o, -step);
      if (state == ST_ADJ && (hold_finish || timeout))
        offset_save_o <= 1'b1;
    end
  end

  // ****************************************
  // indicators and outputs
  // ****************************************
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      blink_cnt <= 29'h0;
      blink_phase <= 1'b0;
      pv_hold <= {TMP_W{1'b0}};
      loop_value_o <= {TMP_W{1'b0}};
      level_o <= {LVL_W{1'b0}};
      diag_msg_o <= 1'b0;
      display_red_o <= 1'b0;
      percent_o <= 7'h00;
    end
    else
    begin
      if (blink_cnt == BLINK_CYC - 1'b1)
      begin
        blink_cnt <= 29'h0;
        blink_phase <= ~blink_phase;
      end
      else
        blink_cnt <= blink_cnt + 1'b1;
      // raising the offset lowers the reported level
      level_o <= level_raw_i - {{(LVL_W-OFS_W){offset_o[OFS_W-1]}}, offset_o};
      if (!alarm_i)
        pv_hold <= pv_sel;
      loop_value_o <= alarm_i ? alarm_value_i : pv_hold;
      diag_msg_o <= alarm_i | warning_i;
      display_red_o <= alarm_i;
      // bar follows the held value, so an alarm freezes it as well
      percent_o <= pct(pv_hold, range_lower_i, range_upper_i);
    end
  end

  assign pv_sel = primary_value_select_i == `SEL_PRODUCT ? product_temp_i :
                  primary_value_select_i == `SEL_WATER ? water_temp_i : liquid_temp_i;

  // ****************************************
  // mode and lock indicators
  // ****************************************
  assign adjust_mode_o = state == ST_ADJ;
  assign blink_all_o = state == ST_ADJ && blink_phase;
  // no menu path reaches the switch level, so software cannot lift it
  assign menu_write_grant_o = menu_write_req_i && !wp_sw;
  assign hw_locked_o = wp_sw;
  assign wp_symbol_o = wp_sw;
  assign legacy_compat_mode_o = compat_sw;
  assign comm_icon_o = hart_active_i && blink_phase;
  assign lock_symbol_o = sw_lock_i;
  assign measure_stop_o = alarm_i;
  // display outputs only; the module has no display input at all

endmodule

//--- test/local_key_switch_control_assertions.sv
// Purpose: port checks of the local key switch control
// Assumes: every port on clk_i
// Notes: bound from the bench top
`timescale 1ns/1ps
module key_ctrl_checker #(parameter OFS_W = 16, parameter TMP_W = 16, parameter LVL_W = 24) (
  input wire clk_i,
  input wire rstn_i,
  input wire menu_write_req_i,
  input wire hart_active_i,
  input wire alarm_i,
  input wire warning_i,
  input wire signed [TMP_W-1:0] alarm_value_i,
  input wire signed [LVL_W-1:0] level_raw_i,
  input wire menu_write_grant_o,
  input wire factory_reset_o,
  input wire adjust_mode_o,
  input wire blink_all_o,
  input wire signed [OFS_W-1:0] offset_o,
  input wire offset_save_o,
  input wire signed [LVL_W-1:0] level_o,
  input wire hw_locked_o,
  input wire wp_symbol_o,
  input wire comm_icon_o,
  input wire measure_stop_o,
  input wire signed [TMP_W-1:0] loop_value_o,
  input wire diag_msg_o,
  input wire display_red_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  grant_lock_a: assert property (menu_write_grant_o == (menu_write_req_i && !hw_locked_o))
    else $error("grant wrong");
  hw_symbol_a: assert property (wp_symbol_o == hw_locked_o)
    else $error("symbol wrong");
  stop_meas_a: assert property (measure_stop_o == alarm_i)
    else $error("stop wrong");
  alarm_out_a: assert property (alarm_i |=> loop_value_o == $past(alarm_value_i) && display_red_o && diag_msg_o)
    else $error("alarm output wrong");
  warn_diag_a: assert property (warning_i && !alarm_i |=> diag_msg_o && !display_red_o)
    else $error("warning wrong");
  blink_adj_a: assert property (blink_all_o |-> adjust_mode_o)
    else $error("blink outside adjust");
  comm_icon_a: assert property (comm_icon_o |-> hart_active_i)
    else $error("icon without traffic");
  step_size_a: assert property ($changed(offset_o) && !factory_reset_o && !$past(factory_reset_o) |->
    (offset_o - $past(offset_o)) inside {16'sh0064, -16'sh0064, 16'sh007f, -16'sh007f})
    else $error("step wrong");
  level_shift_a: assert property ($past(rstn_i) |-> level_o == $past(level_raw_i) - $past(offset_o))
    else $error("level wrong");
  save_adj_a: assert property (offset_save_o |-> $past(adjust_mode_o))
    else $error("save outside adjust");
  cover property (offset_save_o);
  cover property (factory_reset_o);
  cover property (blink_all_o);
endmodule

//--- test/operator_model.sv
// Purpose: operator at the keys and DIP switches
// Assumes: pins high when pressed or ON
// Notes: pins move just after a rising edge
`timescale 1ns/1ps
module operator_model (
  input wire clk_i,
  output reg up_key_o,
  output reg down_key_o,
  output reg wp_sw_o,
  output reg compat_sw_o
);
  // ****************************************
  // actions
  // ****************************************
  initial
  begin
    up_key_o = 1'b0;
    down_key_o = 1'b0;
    wp_sw_o = 1'b0;
    compat_sw_o = 1'b0;
  end
  // both pins on one edge, so a pair is never seen as one key first
  task hold(input [1:0] k, input integer n);
  begin
    @(posedge clk_i);
    {up_key_o, down_key_o} <= k;
    repeat (n) @(posedge clk_i);
    {up_key_o, down_key_o} <= 2'h0;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
  end
  endtask
  task set_sw(input wp, input cm);
  begin
    @(posedge clk_i);
    wp_sw_o <= wp;
    compat_sw_o <= cm;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
  end
  endtask
endmodule

//--- test/local_key_switch_control_tb_top.sv
// Purpose: self-checking bench of the local key switch control
// Assumes: shortened hold counts
// Notes: key timing judged by outcome, filter delay varies
`timescale 1ns/1ps
module local_key_switch_control_tb_top;
  reg clk_i, rstn_i, req, hart, swl, alm, wrn;
  reg [1:0] sel;
  reg [15:0] tl, tp, tw, lo, hi, av, v;
  reg [23:0] raw;
  wire up, dn, wp, cm, grant, fres, inch, adj, blink, save, hwl, wps, leg, comm, lsym, stop, diag, red;
  wire [15:0] ofs, loopv;
  wire [23:0] lvl;
  wire [6:0] pct;
  integer error_cnt, checks_done, c;
  integer saves = 0;
  integer resets = 0;
  operator_model op (.clk_i(clk_i), .up_key_o(up), .down_key_o(dn), .wp_sw_o(wp), .compat_sw_o(cm));
  local_key_switch_control #(.FACTORY_CYC(29'h0c8), .UNIT_CYC(29'h028), .REP_START_CYC(29'h01e),
    .FINISH_CYC(29'h028), .TIMEOUT_CYC(29'h12c), .REPEAT_CYC(29'h005), .BLINK_CYC(29'h004),
    .DEBOUNCE_CYC(20'h00003)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .up_key_i(up), .down_key_i(dn),
    .write_protect_sw_i(wp), .compat_sw_i(cm), .menu_write_req_i(req), .hart_active_i(hart), .sw_lock_i(swl),
    .alarm_i(alm), .warning_i(wrn), .primary_value_select_i(sel), .liquid_temp_i(tl), .product_temp_i(tp),
    .water_temp_i(tw), .range_lower_i(lo), .range_upper_i(hi), .alarm_value_i(av), .level_raw_i(raw),
    .menu_write_grant_o(grant), .factory_reset_o(fres), .unit_inch_o(inch), .adjust_mode_o(adj),
    .blink_all_o(blink), .offset_o(ofs), .offset_save_o(save), .level_o(lvl), .hw_locked_o(hwl),
    .wp_symbol_o(wps), .legacy_compat_mode_o(leg), .comm_icon_o(comm), .lock_symbol_o(lsym),
    .measure_stop_o(stop), .loop_value_o(loopv), .diag_msg_o(diag), .display_red_o(red), .percent_o(pct));
  // ****************************************
  // clock, pulse counters, tasks
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (save === 1'b1)
      saves <= saves + 1;
    if (fres === 1'b1)
      resets <= resets + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    {rstn_i, req, hart, swl, alm, wrn, sel} = 8'h00;
    {lo, hi, tl, tp, tw} = {16'hffd8, 16'h0046, 16'h000f, 16'h0046, 16'hffd8};
    raw = 24'h002710;
    av = 16'h0123;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(8);
    chk(leg, 32'h0);
    chk(pct, 32'h32);
    op.hold(2'h2, 50);
    chk({inch, adj}, 32'h1);
    c = 0;
    repeat (8)
    begin
      @(negedge clk_i);
      c = c + blink;
    end
    chk(c > 0 && c < 8, 32'h1);
    op.hold(2'h2, 10);
    chk(ofs, 32'h0064);
    chk(lvl, 32'h0026ac);
    @(posedge clk_i);
    raw <= 24'hfff000;
    cyc(2);
    chk(lvl, 32'h00ffef9c);
    op.hold(2'h1, 10);
    chk(ofs, 32'h0000);
    op.hold(2'h2, 60);
    chk($signed(ofs) >= 400, 32'h1);
    v = ofs;
    op.hold(2'h3, 50);
    chk({saves[3:0], adj, ofs}, {4'h1, 1'b0, v});
    $display("metric adjust done");
    op.hold(2'h1, 50);
    chk({inch, adj}, 32'h3);
    op.hold(2'h2, 10);
    chk(ofs, v + 16'h007f);
    cyc(400);
    chk({saves[3:0], adj}, 32'h04);
    op.hold(2'h3, 230);
    chk({resets[3:0], inch, ofs}, 32'h20000);
    $display("inch and factory done");
    op.set_sw(1'b1, 1'b1);
    @(posedge clk_i);
    req <= 1'b1;
    swl <= 1'b1;
    cyc(2);
    chk({grant, hwl, wps, leg, lsym}, 32'h0f);
    op.set_sw(1'b0, 1'b0);
    chk({grant, hwl, leg}, 32'h4);
    $display("switches done");
    @(posedge clk_i);
    sel <= 2'h1;
    cyc(4);
    chk(pct, 32'h64);
    @(posedge clk_i);
    sel <= 2'h2;
    cyc(4);
    chk(pct, 32'h00);
    @(posedge clk_i);
    sel <= 2'h3;
    tl <= 16'h0000;
    cyc(4);
    chk(pct, 32'h24);
    @(posedge clk_i);
    hi <= 16'hffd8;
    cyc(4);
    chk(pct, 32'h00);
    @(posedge clk_i);
    hart <= 1'b1;
    c = 0;
    repeat (8)
    begin
      @(negedge clk_i);
      c = c + comm;
    end
    chk(c > 0 && c < 8, 32'h1);
    @(posedge clk_i);
    alm <= 1'b1;
    cyc(3);
    chk({stop, diag, red, loopv}, 32'h70123);
    @(posedge clk_i);
    av <= 16'hff00;
    cyc(2);
    chk(loopv, 32'hff00);
    @(posedge clk_i);
    alm <= 1'b0;
    wrn <= 1'b1;
    cyc(3);
    chk({stop, diag, red}, 32'h2);
    $display("status and percent done");
    end_sim;
  end
  initial
  begin
    cyc(4000);
    error_cnt = error_cnt + 1;
    end_sim;
  end
endmodule
bind local_key_switch_control key_ctrl_checker #(.OFS_W(OFS_W), .TMP_W(TMP_W), .LVL_W(LVL_W)) chk_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .menu_write_req_i(menu_write_req_i), .hart_active_i(hart_active_i),
  .alarm_i(alarm_i), .warning_i(warning_i), .alarm_value_i(alarm_value_i), .level_raw_i(level_raw_i),
  .menu_write_grant_o(menu_write_grant_o), .factory_reset_o(factory_reset_o), .adjust_mode_o(adjust_mode_o),
  .blink_all_o(blink_all_o), .offset_o(offset_o), .offset_save_o(offset_save_o), .level_o(level_o),
  .hw_locked_o(hw_locked_o), .wp_symbol_o(wp_symbol_o), .comm_icon_o(comm_icon_o),
  .measure_stop_o(measure_stop_o), .loop_value_o(loop_value_o), .diag_msg_o(diag_msg_o),
  .display_red_o(display_red_o));
